/* File: common/fifo_pm_pkg.sv */
// Purpose: Shared constants and carrier types for the FIFO level and power registers
// Assumes: AHB-Lite word access, 32-bit data, 50 MHz hclk
// Notes:   Offsets are byte addresses
package fifo_pm_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] rx_fifo_level_info_offset       = 8'h7C;
  localparam logic [7:0] tx_fifo_level_info_offset       = 8'h80;
  localparam logic [7:0] power_management_control_offset = 8'h84;
  localparam logic [7:0] endian_test_offset              = 8'h64;

  // ==========================================================================
  // Field positions
  localparam int status_used_lsb   = 16;
  localparam int power_state_lsb   = 12;
  localparam int phy_reset_bit     = 10;
  localparam int wake_frame_bit    = 9;
  localparam int energy_bit        = 8;
  localparam int drive_type_bit    = 6;
  localparam int pulse_mode_bit    = 3;
  localparam int polarity_bit      = 2;
  localparam int pin_enable_bit    = 1;
  localparam int alive_bit         = 0;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  status_used_reset = 8'h00;
  localparam logic [15:0] rx_data_reset     = 16'h0000;
  localparam logic [15:0] tx_free_reset     = 16'h1200;

  // ==========================================================================
  // Timing
  localparam int clock_mhz            = 50;
  localparam int phy_reset_time_us    = 100;
  localparam int phy_reset_cycles     = phy_reset_time_us * clock_mhz;
  localparam int wake_pulse_time_ms   = 50;
  localparam int wake_pulse_cycles    = wake_pulse_time_ms * 1000 * clock_mhz;
  localparam int alive_settle_cycles  = 16;

  // ==========================================================================
  // Types
  typedef enum logic [1:0]
  {
    state_normal   = 2'b00,
    state_wake_det = 2'b01,
    state_energy   = 2'b10,
    state_reserved = 2'b11
  } power_state_type;

  typedef struct packed
  {
    logic [7:0]  rx_status_used_dwords;
    logic [15:0] rx_data_used_bytes;
    logic [7:0]  tx_status_used_dwords;
    logic [15:0] tx_data_free_bytes;
  } fifo_levels_type;

  typedef struct packed
  {
    logic wake_frame_event;
    logic energy_detect_event;
  } wake_events_type;

endpackage : fifo_pm_pkg

/* File: src/fifo_pm_timer.sv */
// Purpose: Down counter that holds a level for a set number of cycles
// Assumes: start is a one-cycle pulse on hclk
// Notes:   A start while running restarts the count
`timescale 1ns/1ns
`default_nettype none
module fifo_pm_timer #(
  parameter int unsigned cycles = 16
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic clock_enable,
  input  wire logic start,
  output var  logic running
);

  localparam int width = $clog2(cycles + 1);
  localparam logic [width-1:0] load_value = width'(cycles);

  logic [width-1:0] count;

  // ==========================================================================
  // Counter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count   <= '0;
      running <= 1'b0;
    end
    else if (clock_enable)
    begin
      if (start)
      begin
        count   <= load_value;
        running <= 1'b1;
      end
      else if (count > width'(1))
      begin
        count <= count - width'(1);
      end
      else
      begin
        count   <= '0;
        running <= 1'b0;
      end
    end
  end

endmodule : fifo_pm_timer
`default_nettype wire

/* File: src/fifo_pm_regs.sv */
// Purpose: FIFO level info and power management control registers on AHB-Lite
// Assumes: FIFO levels and wake events come from logic on hclk
// Notes:   Zero wait states; unmapped addresses read zero, writes dropped
//
// Contract
// - RX info bits 23:16 report used RX status DWORDs, zero after reset.
// - RX info bits 15:0 report used RX data bytes, zero after reset.
// - TX info bits 23:16 report used TX status DWORDs, zero after reset.
// - TX info bits 15:0 report free TX data bytes, reset 1200h.
// - Power control register stays readable in every reduced power state.
// - Writes are ignored until the host has done one read after reset or wake.
// - Self-clearing bits 13:12 select power state: 00 normal, 01 wake, 10 energy.
// - Any write to the endian test register wakes a reduced-power device.
// - Writing one to bit 10 resets the PHY for at least 100 us.
// - PHY reset bit self-clears at release; writes ignored while set.
// - Bit 9 lets wake frames drive the pin if enabled and always the interrupt.
// - Bit 8 lets energy detect drive the pin if enabled and always the interrupt.
// - Bit 6 clear gives open-drain active low; set gives push-pull.
// - Bit 0 is a read-only alive flag, set once the device is stable.
// - Bit 3 set pulses the wake pin for 50 ms; clear holds it.
// - Bit 2 sets push-pull polarity: one active high, zero active low.
// - Bit 1 enables the wake pin and does not affect the interrupt.
`timescale 1ns/1ns
`default_nettype none
module fifo_pm_regs
  import fifo_pm_pkg::*;
#(
  parameter int unsigned phy_reset_length  = phy_reset_cycles,
  parameter int unsigned wake_pulse_length = wake_pulse_cycles,
  parameter int unsigned alive_settle      = alive_settle_cycles
) (
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            clock_enable,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic            hready,
  input  wire logic [31:0]     hwdata,
  output var  logic [31:0]     hrdata,
  output var  logic            hreadyout,
  output var  logic            hresp,
  input  wire fifo_levels_type fifo_levels,
  input  wire wake_events_type wake_events,
  output var  logic [1:0]      power_state,
  output var  logic            phy_reset,
  output var  logic            wake_event_interrupt,
  output var  logic            wake_output_pin_out,
  output var  logic            wake_output_pin_oe
);

  // ==========================================================================
  // Address phase capture
  logic       data_write;
  logic [7:0] data_addr;
  logic       host_read_seen;
  logic       next_host_read_seen;
  logic       alive;

  wire addr_valid  = hsel && hready && htrans[1];
  wire addr_read   = addr_valid && !hwrite;
  wire addr_write  = addr_valid && hwrite;
  wire write_ok    = data_write && host_read_seen;
  wire wr_endian   = data_write && (data_addr == endian_test_offset);
  wire wr_pmc      = write_ok && (data_addr == power_management_control_offset);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      data_write <= 1'b0;
      data_addr  <= 8'h00;
    end
    else if (clock_enable)
    begin
      data_write <= addr_write;
      data_addr  <= haddr[7:0];
    end
  end

  // ==========================================================================
  // Power state and wake
  power_state_type mode;
  logic            reduced;
  logic            wake_now;

  assign reduced  = (mode != state_normal);
  assign wake_now = reduced && wr_endian;

  wire [1:0] written_state = hwdata[power_state_lsb+1:power_state_lsb];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode <= state_normal;
    end
    else if (clock_enable)
    begin
      if (wake_now)
      begin
        mode <= state_normal;
      end
      else if (wr_pmc && !reduced && written_state != 2'b11)
      begin
        mode <= power_state_type'(written_state);
      end
    end
  end

  // Alive settles after reset and after each wake
  logic settling;
  logic settle_start;
  logic reset_kick;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      reset_kick <= 1'b1;
    end
    else if (clock_enable)
    begin
      reset_kick <= 1'b0;
    end
  end

  assign settle_start = reset_kick || wake_now;

  fifo_pm_timer #(.cycles(alive_settle)) settle_timer (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .clock_enable(clock_enable),
    .start       (settle_start),
    .running     (settling)
  );

  assign alive = !reset_kick && !settling && !reduced;

  // Read seen flag: cleared on wake, set by any read
  assign next_host_read_seen = addr_read ? 1'b1 : (wake_now ? 1'b0 : host_read_seen);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      host_read_seen <= 1'b0;
    end
    else if (clock_enable)
    begin
      host_read_seen <= next_host_read_seen;
    end
  end

  // ==========================================================================
  // Control bits
  logic wake_frame_event_enable;
  logic energy_detect_event_enable;
  logic wake_pin_drive_type;
  logic wake_pin_pulse_mode;
  logic wake_pin_polarity;
  logic wake_pin_enable;
  logic phy_reset_request;
  logic phy_reset_start;
  logic phy_reset_running;

  assign phy_reset_start = wr_pmc && !phy_reset_request && hwdata[phy_reset_bit];

  fifo_pm_timer #(.cycles(phy_reset_length)) phy_timer (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .clock_enable(clock_enable),
    .start       (phy_reset_start),
    .running     (phy_reset_running)
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wake_frame_event_enable    <= 1'b0;
      energy_detect_event_enable <= 1'b0;
      wake_pin_drive_type        <= 1'b0;
      wake_pin_pulse_mode        <= 1'b0;
      wake_pin_polarity          <= 1'b0;
      wake_pin_enable            <= 1'b0;
      phy_reset_request          <= 1'b0;
    end
    else if (clock_enable)
    begin
      if (wr_pmc)
      begin
        wake_frame_event_enable    <= hwdata[wake_frame_bit];
        energy_detect_event_enable <= hwdata[energy_bit];
        wake_pin_drive_type        <= hwdata[drive_type_bit];
        wake_pin_pulse_mode        <= hwdata[pulse_mode_bit];
        wake_pin_polarity          <= hwdata[polarity_bit];
        wake_pin_enable            <= hwdata[pin_enable_bit];
      end
      if (phy_reset_start)
      begin
        phy_reset_request <= 1'b1;
      end
      else if (phy_reset_request && !phy_reset_running)
      begin
        phy_reset_request <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Wake event indication
  logic wake_active;
  logic pulse_running;

  wire frame_hit  = wake_frame_event_enable && wake_events.wake_frame_event;
  wire energy_hit = energy_detect_event_enable && wake_events.energy_detect_event;
  wire any_hit    = frame_hit || energy_hit;
  wire pulse_start = any_hit && wake_pin_pulse_mode && !pulse_running;

  fifo_pm_timer #(.cycles(wake_pulse_length)) pulse_timer (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .clock_enable(clock_enable),
    .start       (pulse_start),
    .running     (pulse_running)
  );

  // Static indication holds until both event enables are cleared
  wire static_on = wake_frame_event_enable && wake_events.wake_frame_event
                   || energy_detect_event_enable && wake_events.energy_detect_event
                   || (wake_active && (wake_frame_event_enable || energy_detect_event_enable));
  wire next_wake_active = wake_pin_pulse_mode ? pulse_running : static_on;
  wire pin_assert = wake_pin_enable && wake_active;
  wire pin_level  = wake_pin_polarity ? pin_assert : !pin_assert;
  wire next_pin_out = wake_pin_drive_type ? pin_level : 1'b0;
  wire next_pin_oe  = wake_pin_drive_type ? 1'b1 : pin_assert;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wake_active          <= 1'b0;
      wake_event_interrupt <= 1'b0;
      wake_output_pin_out  <= 1'b0;
      wake_output_pin_oe   <= 1'b0;
    end
    else if (clock_enable)
    begin
      wake_active          <= next_wake_active;
      wake_event_interrupt <= any_hit;
      wake_output_pin_out  <= next_pin_out;
      wake_output_pin_oe   <= next_pin_oe;
    end
  end

  // ==========================================================================
  // Read data
  wire [31:0] rx_info = {8'h00, fifo_levels.rx_status_used_dwords,
                         fifo_levels.rx_data_used_bytes};
  wire [31:0] tx_info = {8'h00, fifo_levels.tx_status_used_dwords,
                         fifo_levels.tx_data_free_bytes};
  wire [31:0] pmc_value = {18'h00000, mode, 1'b0, phy_reset_request,
                           wake_frame_event_enable, energy_detect_event_enable,
                           1'b0, wake_pin_drive_type, 2'b00, wake_pin_pulse_mode,
                           wake_pin_polarity, wake_pin_enable, alive};
  wire [7:0]  ra = haddr[7:0];
  wire [31:0] next_rdata = (ra == rx_fifo_level_info_offset)       ? rx_info :
                           (ra == tx_fifo_level_info_offset)       ? tx_info :
                           (ra == power_management_control_offset) ? pmc_value :
                           32'h00000000;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h00000000;
    end
    else if (clock_enable && addr_read)
    begin
      hrdata <= next_rdata;
    end
  end

  // ==========================================================================
  // Bus response and power outputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      power_state <= 2'b00;
      phy_reset   <= 1'b0;
    end
    else if (clock_enable)
    begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      power_state <= mode;
      phy_reset   <= phy_reset_start || phy_reset_running;
    end
  end

endmodule : fifo_pm_regs
`default_nettype wire

/* File: testbench/fifo_pm_host.sv */
// Purpose: Host model issuing single AHB-Lite word transfers
// Assumes: One slave; its hreadyout is hready
// Notes:   Waits are bounded; an overrun sets timed_out
`timescale 1ns/1ns
`default_nettype none
module fifo_pm_host (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [31:0] hwdata,
  output var  logic        timed_out
);
  // ==========================================================================
  // Transfers
  initial
  begin
    {hsel, haddr, htrans, hwrite, hwdata, timed_out} = '0;
  end

  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 50);
    if (n >= 50)
      timed_out = 1'b1;
  endtask : wait_ready

  // Starts right after a rising edge; no TX data is pushed
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
    if (w && a == 32'h84 && d[13:12] == 2'b11)
      d[13:12] = 2'b00;
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : ~hwdata;
    wait_ready();
    q = hrdata;
  endtask : xfer
endmodule : fifo_pm_host
`default_nettype wire

/* File: testbench/fifo_pm_regs_sva.sv */
// Purpose: Checker for the FIFO level and power register ports
// Assumes: One clock, async active-low reset
// Notes:   Bound to every register block instance
`timescale 1ns/1ns
`default_nettype none
module fifo_pm_regs_sva
  import fifo_pm_pkg::*;
#(
  parameter int unsigned phy_reset_length = phy_reset_cycles
) (
  input wire logic            hclk,
  input wire logic            hresetn,
  input wire logic            clock_enable,
  input wire logic            hsel,
  input wire logic [31:0]     haddr,
  input wire logic [1:0]      htrans,
  input wire logic            hwrite,
  input wire logic            hready,
  input wire logic [31:0]     hrdata,
  input wire logic            hreadyout,
  input wire logic            hresp,
  input wire fifo_levels_type fifo_levels,
  input wire wake_events_type wake_events,
  input wire logic [1:0]      power_state,
  input wire logic            phy_reset,
  input wire logic            wake_event_interrupt
);
  // ==========================================================================
  // Helpers
  int unsigned held;
  wire logic   rd_go = hsel && hready && htrans[1] && !hwrite && clock_enable;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      held <= 0;
    else if (clock_enable)
      held <= phy_reset ? held + 1 : 0;

  // ==========================================================================
  // Properties
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("Slave stalled or answered an error");
  state_legal_a: assert property (power_state != 2'b11)
    else $error("Power state took the reserved code");
  phy_hold_a: assert property ($fell(phy_reset) |-> held == phy_reset_length + 1)
    else $error("PHY reset held for the wrong time");
  irq_cause_a: assert property (wake_event_interrupt |-> $past(wake_events) != 2'b00)
    else $error("Interrupt without an event");
  rx_read_a: assert property (rd_go && haddr == 32'h7C |=>
    hrdata == {8'h00, $past(fifo_levels[47:24])}) else $error("RX level read wrong");
  tx_read_a: assert property (rd_go && haddr == 32'h80 |=>
    hrdata == {8'h00, $past(fifo_levels[23:0])}) else $error("TX level read wrong");
  mode_read_a: assert property (rd_go && haddr == 32'h84 |=>
    hrdata[31:14] == 18'h0 && hrdata[13:12] == $past(power_state))
    else $error("Power state read wrong");
  alive_low_a: assert property (rd_go && haddr == 32'h84 && power_state != 2'b00 |=>
    !hrdata[0]) else $error("Alive flag set in reduced power");
  read_reduced_c: cover property (rd_go && power_state != 2'b00);
  phy_done_c: cover property ($fell(phy_reset));
  wake_irq_c: cover property (wake_event_interrupt);
endmodule : fifo_pm_regs_sva
bind fifo_pm_regs fifo_pm_regs_sva #(.phy_reset_length(phy_reset_length)) chk (
  .hclk, .hresetn, .clock_enable, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
  .hreadyout, .hresp, .fifo_levels, .wake_events, .power_state, .phy_reset,
  .wake_event_interrupt
);
`default_nettype wire

/* File: testbench/tb.sv */
// Purpose: Self-checking bench for the FIFO level and power registers
// Assumes: Short timing parameters; host model drives the bus
// Notes:   Expected values come from an integer model of the registers
`timescale 1ns/1ns
`default_nettype none
module tb;
  import fifo_pm_pkg::*;
  localparam int unsigned prl = 8;
  localparam int unsigned wpl = 20;
  logic            hclk, hresetn, hsel, hwrite, hreadyout, hresp, timed_out;
  logic            irq, pin_out, pin_oe, phy_reset, ce;
  logic [1:0]      htrans, power_state;
  logic [31:0]     haddr, hwdata, hrdata;
  logic [15:0]     lf;
  fifo_levels_type lv;
  wake_events_type ev;
  int              error_cnt, total_checks, rs, ps, bits, ph, alv, n;

  fifo_pm_host host (
    .hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hwdata, .timed_out
  );
  fifo_pm_regs #(.phy_reset_length(prl), .wake_pulse_length(wpl), .alive_settle(4)) dut (
    .hclk, .hresetn, .clock_enable(ce), .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .fifo_levels(lv),
    .wake_events(ev), .power_state, .phy_reset, .wake_event_interrupt(irq),
    .wake_output_pin_out(pin_out), .wake_output_pin_oe(pin_oe)
  );

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp || timed_out === 1'b1)
    begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      if (timed_out === 1'b1)
        test_done();
    end
  endtask : check

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(a, 1'b1, d, q);
    if (a == 32'h84 && rs == 1 && ps == 0)
    begin
      bits = d & 32'h0000_034E;
      ps   = d[13:12];
      ph   = ph | d[10];
      alv  = ps == 0;
    end
    if (a == 32'h64 && ps != 0)
    begin
      ps = 0;
      rs = 0;
    end
  endtask : wr

  task automatic rd(input logic [31:0] a);
    logic [31:0] q, e;
    host.xfer(a, 1'b0, 32'h0, q);
    e = a == 32'h7C ? {8'h00, lv[47:24]} : a == 32'h80 ? {8'h00, lv[23:0]} : 32'h0;
    if (a == 32'h84)
      e = bits | ps << 12 | ph << 10 | alv;
    rs = 1;
    check(q, e);
  endtask : rd

  task automatic wake(input logic [31:0] c, input logic [1:0] e);
    logic v, a;
    v = (e[1] & c[9]) | (e[0] & c[8]);
    a = v & c[1];
    wr(32'h84, c);
    ev <= e;
    repeat (3) @(posedge hclk);
    check({irq, pin_oe, pin_out}, {v, c[6] | a, c[6] & (a ^ !c[2])});
    ev <= 2'b00;
    repeat (3) @(posedge hclk);
    check({irq, pin_oe, pin_out}, {1'b0, c[6] | a, c[6] & (a ^ !c[2])});
    wr(32'h84, 32'h0);
    repeat (3) @(posedge hclk);
  endtask : wake

  // ==========================================================================
  // Stimulus
  initial
  begin
    hclk = 1'b0;
    forever
      #10 hclk = ~hclk;
  end

  initial
  begin
    #1000000;
    error_cnt++;
    test_done();
  end

  initial
  begin
    hresetn = 1'b0;
    lf      = 16'h004B;
    lv      = {8'h00, 16'h0000, 8'h00, 16'h1200};
    ev      = 2'b00;
    ce      = 1'b1;
    {error_cnt, total_checks, rs, ps, bits, ph, alv} = '0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (10) @(posedge hclk);
    alv = 1;
    wr(32'h84, 32'h0000_034E);
    rd(32'h84);
    rd(32'h7C);
    rd(32'h80);
    rd(32'h40);
    wr(32'h84, 32'h0000_034E);
    rd(32'h84);
    repeat (6)
    begin
      lf = lfsr(lf);
      lv <= {lf[7:0], lf, lf[15:8], ~lf};
      @(posedge hclk);
      rd(32'h7C);
      rd(32'h80);
    end
    wake(32'h0000_0242, 2'b10);
    wake(32'h0000_0146, 2'b01);
    wake(32'h0000_0102, 2'b01);
    wake(32'h0000_0144, 2'b01);
    wake(32'h0000_0242, 2'b01);
    wr(32'h84, 32'h0000_020A);
    ev <= 2'b10;
    @(posedge hclk);
    ev <= 2'b00;
    n = 0;
    repeat (60)
    begin
      @(posedge hclk);
      n += pin_oe;
    end
    check(n, wpl);
    wr(32'h84, 32'h0000_0400);
    rd(32'h84);
    wr(32'h84, 32'h0000_0400);
    ce <= 1'b0;
    repeat (6) @(posedge hclk);
    ce <= 1'b1;
    check(phy_reset, 1'b1);
    rd(32'h84);
    repeat (prl + 4) @(posedge hclk);
    ph = 0;
    check(phy_reset, 1'b0);
    rd(32'h84);
    for (int m = 1; m < 3; m++)
    begin
      wr(32'h84, m << 12);
      repeat (2) @(posedge hclk);
      check(power_state, m);
      rd(32'h84);
      wr(32'h64, 32'h0);
      repeat (2) @(posedge hclk);
      check(power_state, 0);
      repeat (10) @(posedge hclk);
      alv = 1;
      wr(32'h84, 32'h0000_0306);
      rd(32'h84);
    end
    test_done();
  end
endmodule : tb
`default_nettype wire
